// ### design/mwd_decoder.sv
// instruction word decoder top: word sequencing, opcode decode and register slave
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.svh"
module mwd_decoder #(
  parameter int INSTR_W = 16
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [15:0] INSTR_WORD_IN,
  input  wire logic        INSTR_VALID_IN,
  input  wire logic        COND_TRUE_IN,
  output logic             DEC_VALID_OUT,
  output logic      [5:0]  DEC_OP_OUT,
  output logic             DEST_FILE_OUT,
  output logic      [11:0] FILE_ADDR_OUT,
  output logic      [11:0] DEST_ADDR_OUT,
  output logic      [2:0]  BIT_SEL_OUT,
  output logic      [7:0]  LITERAL_OUT,
  output logic      [19:0] TARGET_OUT,
  output logic      [10:0] REL_OFFSET_OUT,
  output logic             FAST_OUT,
  output logic      [4:0]  FLAG_MASK_OUT,
  output logic      [1:0]  CYCLES_OUT,
  output logic             SKIP_TEST_OUT,
  output logic             READ_PINS_OUT
);
  if (INSTR_W != 16) begin : g_width_check
    $error("mwd_decoder serves 16-bit instruction words only");
  end

  mwd_fields_if fld ();
  mwd_field_extract u_extract (
    .f (fld)
  );

  mwd_pkg::mwd_state_t state_q, state_d;
  mwd_pkg::mwd_op_t    op_c, held_op_q;
  logic [4:0]  mask_c;
  logic        two_word_c, alters_pc_c, cond_c, rmw_c, is_rel_c;
  logic [3:0]  bank_q;
  logic [15:0] count_q;
  logic        bad_second_q, cond_pending_q;
  logic [11:0] held_src_q;
  logic [7:0]  held_lo_q;
  logic        held_fast_q;
  logic        flush_now, second_ok, in_port;
  logic        apb_setup, apb_access, apb_mapped;
  logic [31:0] rdata_c;
  logic [31:0] rdata_q;

  assign fld.word = INSTR_WORD_IN;
  assign fld.bank = bank_q;

  // opcode decode of a first word
  always_comb begin
    op_c        = mwd_pkg::OP_UNDECODED;
    mask_c      = `MWD_MASK_NONE;
    two_word_c  = 1'b0;
    alters_pc_c = 1'b0;
    cond_c      = 1'b0;
    rmw_c       = 1'b0;
    is_rel_c    = 1'b0;
    case (INSTR_WORD_IN[15:12])
      4'h0: begin
        if (INSTR_WORD_IN[11:9] == 3'b001) begin
          op_c = mwd_pkg::OP_WORKING_TIMES_FILE;
        end else if (INSTR_WORD_IN[11]) begin
          op_c = mwd_pkg::OP_LITERAL;
        end else if (INSTR_WORD_IN[11:0] == 12'h000) begin
          op_c = mwd_pkg::OP_NOP;
        end
      end
      4'h1: begin
        rmw_c  = 1'b1;
        mask_c = `MWD_MASK_ZN;
        case (INSTR_WORD_IN[11:10])
          2'b01:   op_c = mwd_pkg::OP_WORKING_AND_FILE;
          2'b00:   op_c = mwd_pkg::OP_WORKING_OR_FILE;
          2'b10:   op_c = mwd_pkg::OP_WORKING_XOR_FILE;
          default: op_c = mwd_pkg::OP_FILE_COMPLEMENT;
        endcase
      end
      4'h2: begin
        rmw_c = 1'b1;
        case (INSTR_WORD_IN[11:10])
          2'b01: begin
            op_c   = mwd_pkg::OP_ADD_WORKING_TO_FILE;
            mask_c = `MWD_MASK_ARITH;
          end
          2'b00: begin
            op_c   = mwd_pkg::OP_ADD_WITH_CARRY_TO_FILE;
            mask_c = `MWD_MASK_ARITH;
          end
          2'b10: begin
            op_c   = mwd_pkg::OP_INCREMENT_FILE;
            mask_c = `MWD_MASK_ARITH;
          end
          default: begin
            op_c   = mwd_pkg::OP_DECREMENT_SKIP_ZERO;
            cond_c = 1'b1;
          end
        endcase
      end
      4'h3: begin
        rmw_c = 1'b1;
        case (INSTR_WORD_IN[11:10])
          2'b11: begin
            op_c   = mwd_pkg::OP_INCREMENT_SKIP_ZERO;
            cond_c = 1'b1;
          end
          2'b01: begin
            op_c   = mwd_pkg::OP_LEFT_ROTATE_THROUGH_CARRY;
            mask_c = `MWD_MASK_CZN;
          end
          2'b00: begin
            op_c   = mwd_pkg::OP_RIGHT_ROTATE_THROUGH_CARRY;
            mask_c = `MWD_MASK_CZN;
          end
          default: rmw_c = 1'b0;
        endcase
      end
      4'h4: begin
        rmw_c = 1'b1;
        case (INSTR_WORD_IN[11:10])
          2'b10: begin
            op_c   = mwd_pkg::OP_INCREMENT_SKIP_NONZERO;
            cond_c = 1'b1;
          end
          2'b11: begin
            op_c   = mwd_pkg::OP_DECREMENT_SKIP_NONZERO;
            cond_c = 1'b1;
          end
          2'b01: begin
            op_c   = mwd_pkg::OP_LEFT_ROTATE_PLAIN;
            mask_c = `MWD_MASK_ZN;
          end
          default: begin
            op_c   = mwd_pkg::OP_RIGHT_ROTATE_PLAIN;
            mask_c = `MWD_MASK_ZN;
          end
        endcase
      end
      4'h5: begin
        rmw_c  = 1'b1;
        mask_c = `MWD_MASK_ARITH;
        case (INSTR_WORD_IN[11:10])
          2'b11:   op_c = mwd_pkg::OP_FILE_MINUS_WORKING;
          2'b10:   op_c = mwd_pkg::OP_FILE_MINUS_WORKING_BORROW;
          2'b01:   op_c = mwd_pkg::OP_WORKING_MINUS_FILE_BORROW;
          default: begin
            rmw_c  = 1'b0;
            mask_c = `MWD_MASK_NONE;
          end
        endcase
      end
      4'h6: begin
        cond_c = 1'b1;
        case (INSTR_WORD_IN[11:9])
          3'b001:  op_c = mwd_pkg::OP_COMPARE_SKIP_EQUAL;
          3'b010:  op_c = mwd_pkg::OP_COMPARE_SKIP_GREATER;
          3'b000:  op_c = mwd_pkg::OP_COMPARE_SKIP_LESS;
          default: cond_c = 1'b0;
        endcase
      end
      4'h9: begin
        op_c  = mwd_pkg::OP_FILE_BIT_CLEAR;
        rmw_c = 1'b1;
      end
      4'hB: begin
        op_c   = mwd_pkg::OP_BIT_TEST_SKIP_CLEAR;
        cond_c = 1'b1;
      end
      4'hC: begin
        op_c       = mwd_pkg::OP_FILE_TO_FILE_MOVE;
        two_word_c = 1'b1;
      end
      4'hD: begin
        if (!INSTR_WORD_IN[11]) begin
          op_c        = mwd_pkg::OP_UNCONDITIONAL_RELATIVE_JUMP;
          alters_pc_c = 1'b1;
          is_rel_c    = 1'b1;
        end
      end
      4'hE: begin
        if (INSTR_WORD_IN[11:8] == 4'hF) begin
          op_c        = mwd_pkg::OP_ABSOLUTE_JUMP;
          two_word_c  = 1'b1;
          alters_pc_c = 1'b1;
        end else if (INSTR_WORD_IN[11:9] == 3'b110) begin
          op_c        = mwd_pkg::OP_SUBROUTINE_CALL;
          two_word_c  = 1'b1;
          alters_pc_c = 1'b1;
        end else if (!INSTR_WORD_IN[11]) begin
          op_c     = (INSTR_WORD_IN[10:8] == 3'b010) ? mwd_pkg::OP_JUMP_ON_CARRY_SET
                                                     : mwd_pkg::OP_CONDITIONAL_JUMP;
          cond_c   = 1'b1;
          is_rel_c = 1'b1;
        end
      end
      4'hF: op_c = mwd_pkg::OP_NOP;
      default: op_c = mwd_pkg::OP_UNDECODED;
    endcase
  end

  // a true test or a pc change turns the following word into a nop cycle
  assign flush_now = (state_q == mwd_pkg::ST_FLUSH) || (cond_pending_q && COND_TRUE_IN);
  assign second_ok = (INSTR_WORD_IN[15:12] == `MWD_PFX_SECOND);
  assign in_port   = (fld.file_addr >= `MWD_PORT_LO) && (fld.file_addr <= `MWD_PORT_HI);

  always_comb begin
    state_d = state_q;
    case (state_q)
      mwd_pkg::ST_FIRST: begin
        if (INSTR_VALID_IN && !flush_now) begin
          if (two_word_c) begin
            state_d = mwd_pkg::ST_SECOND;
          end else if (alters_pc_c) begin
            state_d = mwd_pkg::ST_FLUSH;
          end
        end
      end
      mwd_pkg::ST_SECOND: begin
        if (INSTR_VALID_IN) begin
          state_d = (held_op_q == mwd_pkg::OP_FILE_TO_FILE_MOVE) ? mwd_pkg::ST_FIRST
                                                                 : mwd_pkg::ST_FLUSH;
        end
      end
      mwd_pkg::ST_FLUSH: begin
        if (INSTR_VALID_IN) begin
          state_d = mwd_pkg::ST_FIRST;
        end
      end
      default: state_d = mwd_pkg::ST_FIRST;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= mwd_pkg::ST_FIRST;
    end else begin
      state_q <= state_d;
    end
  end

  // a conditional instruction waits for its test result until the next word arrives
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cond_pending_q <= 1'b0;
    end else if (INSTR_VALID_IN) begin
      cond_pending_q <= (state_q == mwd_pkg::ST_FIRST) && !flush_now && cond_c;
    end
  end

  // first word of a two-word instruction is held until its second word
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      held_op_q   <= mwd_pkg::OP_NOP;
      held_src_q  <= 12'h000;
      held_lo_q   <= 8'h00;
      held_fast_q <= 1'b0;
    end else if (INSTR_VALID_IN && state_q == mwd_pkg::ST_FIRST && !flush_now && two_word_c) begin
      held_op_q   <= op_c;
      held_src_q  <= fld.long_addr;
      held_lo_q   <= INSTR_WORD_IN[7:0];
      held_fast_q <= INSTR_WORD_IN[`MWD_S_BIT];
    end
  end

  // decoded outputs, one pulse per instruction or flushed word (as a nop), a two-word one pulsing on its second word only
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DEC_VALID_OUT  <= 1'b0;
      DEC_OP_OUT     <= 6'h00;
      DEST_FILE_OUT  <= 1'b0;
      FILE_ADDR_OUT  <= 12'h000;
      DEST_ADDR_OUT  <= 12'h000;
      BIT_SEL_OUT    <= 3'h0;
      LITERAL_OUT    <= 8'h00;
      TARGET_OUT     <= 20'h00000;
      REL_OFFSET_OUT <= 11'h000;
      FAST_OUT       <= 1'b0;
      FLAG_MASK_OUT  <= `MWD_MASK_NONE;
      CYCLES_OUT     <= `MWD_CYC_ONE;
      SKIP_TEST_OUT  <= 1'b0;
      READ_PINS_OUT  <= 1'b0;
    end else begin
      DEC_VALID_OUT <= 1'b0;
      if (INSTR_VALID_IN) begin
        DEC_OP_OUT     <= mwd_pkg::OP_NOP;
        FLAG_MASK_OUT  <= `MWD_MASK_NONE;
        CYCLES_OUT     <= `MWD_CYC_ONE;
        SKIP_TEST_OUT  <= 1'b0;
        READ_PINS_OUT  <= 1'b0;
        FAST_OUT       <= 1'b0;
        if (state_q == mwd_pkg::ST_SECOND) begin
          DEC_VALID_OUT <= 1'b1;
          CYCLES_OUT    <= `MWD_CYC_TWO;
          DEC_OP_OUT    <= second_ok ? held_op_q : mwd_pkg::OP_UNDECODED;
          FILE_ADDR_OUT <= held_src_q;
          DEST_ADDR_OUT <= fld.long_addr;
          TARGET_OUT    <= {fld.long_addr, held_lo_q};
          FAST_OUT      <= (held_op_q == mwd_pkg::OP_SUBROUTINE_CALL) && held_fast_q;
        end else if (flush_now) begin
          DEC_VALID_OUT <= 1'b1;
        end else if (!two_word_c) begin
          DEC_VALID_OUT  <= 1'b1;
          DEC_OP_OUT     <= op_c;
          DEST_FILE_OUT  <= fld.dest_file;
          FILE_ADDR_OUT  <= fld.file_addr;
          BIT_SEL_OUT    <= fld.bit_sel;
          LITERAL_OUT    <= fld.literal;
          REL_OFFSET_OUT <= (INSTR_WORD_IN[15:12] == 4'hD) ? fld.rel_long
                                                           : fld.rel_short;
          FLAG_MASK_OUT  <= mask_c;
          CYCLES_OUT     <= (alters_pc_c && is_rel_c) ? `MWD_CYC_TWO : `MWD_CYC_ONE;
          SKIP_TEST_OUT  <= cond_c;
          READ_PINS_OUT  <= rmw_c && in_port;
        end
      end
    end
  end

  // software-visible bookkeeping
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bad_second_q <= 1'b0;
    end else if (INSTR_VALID_IN && state_q == mwd_pkg::ST_SECOND) begin
      bad_second_q <= !second_ok;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      count_q <= `MWD_COUNT_RST;
    end else if (DEC_VALID_OUT) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // register slave: zero wait states, error on unmapped offsets
  assign apb_setup  = PSEL_IN && !PENABLE_IN;
  assign apb_access = PSEL_IN && PENABLE_IN;
  assign apb_mapped = (PADDR_IN == `MWD_OFS_CTRL) || (PADDR_IN == `MWD_OFS_STATUS) ||
                      (PADDR_IN == `MWD_OFS_COUNT);
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = apb_access && !apb_mapped;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bank_q <= `MWD_CTRL_RST;
    end else if (apb_access && PWRITE_IN && PADDR_IN == `MWD_OFS_CTRL) begin
      bank_q <= PWDATA_IN[`MWD_BANK_MSB:`MWD_BANK_LSB];
    end
  end

  always_comb begin
    rdata_c = 32'h0000_0000;
    case (PADDR_IN)
      `MWD_OFS_CTRL:   rdata_c[`MWD_BANK_MSB:`MWD_BANK_LSB] = bank_q;
      `MWD_OFS_STATUS: begin
        rdata_c[`MWD_ST_OP_LSB +: 6]    = DEC_OP_OUT;
        rdata_c[`MWD_ST_STATE_LSB +: 2] = state_q;
        rdata_c[`MWD_ST_BADSEC_BIT]     = bad_second_q;
        rdata_c[`MWD_ST_CONDP_BIT]      = cond_pending_q;
      end
      `MWD_OFS_COUNT:  rdata_c[15:0] = count_q;
      default:         rdata_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      rdata_q <= rdata_c;
    end
  end

  assign PRDATA_OUT = rdata_q;
endmodule
`default_nettype wire

// ### design/mwd_defs.svh
// offsets, field positions, reset values and flag masks of the instruction word decoder
`ifndef MWD_DEFS_SVH
`define MWD_DEFS_SVH
`define MWD_OFS_CTRL        8'h00
`define MWD_OFS_STATUS      8'h04
`define MWD_OFS_COUNT       8'h08
`define MWD_CTRL_RST        4'h0
`define MWD_COUNT_RST       16'h0000
`define MWD_BANK_LSB        0
`define MWD_BANK_MSB        3
`define MWD_ST_OP_LSB       0
`define MWD_ST_STATE_LSB    8
`define MWD_ST_BADSEC_BIT   12
`define MWD_ST_CONDP_BIT    13
`define MWD_D_BIT           9
`define MWD_A_BIT           8
`define MWD_S_BIT           8
`define MWD_PFX_SECOND      4'hF
`define MWD_ACCESS_BANK     4'h0
`define MWD_PORT_LO         12'hF80
`define MWD_PORT_HI         12'hF84
`define MWD_FLG_C           0
`define MWD_FLG_DC          1
`define MWD_FLG_Z           2
`define MWD_FLG_OV          3
`define MWD_FLG_N           4
`define MWD_MASK_NONE       5'h00
`define MWD_MASK_ARITH      5'h1F
`define MWD_MASK_ZN         5'h14
`define MWD_MASK_CZN        5'h15
`define MWD_CYC_ONE         2'h1
`define MWD_CYC_TWO         2'h2
`endif

// ### design/mwd_field_extract.sv
// combinational extraction of operand fields from one instruction word
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.svh"
module mwd_field_extract (
  mwd_fields_if.extract f
);
  logic [7:0] short_f;

  assign short_f      = f.word[7:0];
  assign f.dest_file  = f.word[`MWD_D_BIT];
  assign f.banked     = f.word[`MWD_A_BIT];
  // fixed access bank or bank selector supplies the upper address bits
  assign f.file_addr  = f.banked ? {f.bank, short_f}
                                     : {`MWD_ACCESS_BANK, short_f};
  assign f.long_addr  = f.word[11:0];
  assign f.bit_sel    = f.word[11:9];
  assign f.literal    = f.word[7:0];
  assign f.rel_long   = f.word[10:0];
  assign f.rel_short  = {{3{f.word[7]}}, f.word[7:0]};
endmodule
`default_nettype wire

// ### design/mwd_fields_if.sv
// operand fields passed from the field extractor to the decoder
`timescale 1ns/1ps
`default_nettype none
interface mwd_fields_if;
  logic [15:0] word;
  logic [3:0]  bank;
  logic        dest_file;
  logic        banked;
  logic [11:0] file_addr;
  logic [11:0] long_addr;
  logic [2:0]  bit_sel;
  logic [7:0]  literal;
  logic [10:0] rel_long;
  logic [10:0] rel_short;
  modport extract (input word, bank, output dest_file, banked, file_addr, long_addr, bit_sel, literal,
                   rel_long, rel_short);
  modport decode  (output word, bank, input dest_file, banked, file_addr, long_addr, bit_sel, literal,
                   rel_long, rel_short);
endinterface
`default_nettype wire

// ### design/mwd_pkg.sv
// types shared by the instruction word decoder
package mwd_pkg;
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,
    ST_SECOND = 2'b01,
    ST_FLUSH  = 2'b11
  } mwd_state_t;

  typedef enum logic [5:0] {
    OP_NOP, OP_UNDECODED, OP_LITERAL,
    OP_ADD_WORKING_TO_FILE, OP_ADD_WITH_CARRY_TO_FILE, OP_INCREMENT_FILE,
    OP_WORKING_AND_FILE, OP_WORKING_OR_FILE, OP_WORKING_XOR_FILE, OP_FILE_COMPLEMENT,
    OP_WORKING_TIMES_FILE,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_GREATER, OP_COMPARE_SKIP_LESS,
    OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO,
    OP_INCREMENT_SKIP_NONZERO, OP_DECREMENT_SKIP_NONZERO,
    OP_LEFT_ROTATE_THROUGH_CARRY, OP_RIGHT_ROTATE_THROUGH_CARRY,
    OP_LEFT_ROTATE_PLAIN, OP_RIGHT_ROTATE_PLAIN,
    OP_FILE_MINUS_WORKING, OP_FILE_MINUS_WORKING_BORROW, OP_WORKING_MINUS_FILE_BORROW,
    OP_FILE_BIT_CLEAR, OP_BIT_TEST_SKIP_CLEAR,
    OP_FILE_TO_FILE_MOVE, OP_ABSOLUTE_JUMP, OP_SUBROUTINE_CALL,
    OP_UNCONDITIONAL_RELATIVE_JUMP, OP_JUMP_ON_CARRY_SET, OP_CONDITIONAL_JUMP
  } mwd_op_t;
endpackage

// ### verification/mwd_decoder_checker.sv
// concurrent checks on the decoded outputs of the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module mwd_decoder_checker (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [15:0] INSTR_WORD_IN,
  input  wire logic        INSTR_VALID_IN,
  input  wire logic        DEC_VALID_OUT,
  input  wire logic [5:0]  DEC_OP_OUT,
  input  wire logic [4:0]  FLAG_MASK_OUT,
  input  wire logic [7:0]  LITERAL_OUT,
  input  wire logic [19:0] TARGET_OUT,
  input  wire logic [11:0] DEST_ADDR_OUT,
  input  wire logic [2:0]  BIT_SEL_OUT,
  input  wire logic [10:0] REL_OFFSET_OUT,
  input  wire logic [1:0]  CYCLES_OUT
);
  logic [15:0] word_q;
  logic        valid_q;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // word on the bus one cycle earlier, taken or not, the cause of the current pulse
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      word_q  <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      word_q  <= INSTR_WORD_IN;
      valid_q <= INSTR_VALID_IN;
    end
  end
  a_add_full_mask: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_ADD_WORKING_TO_FILE
    |-> FLAG_MASK_OUT == 5'h1F && word_q[15:10] == 6'h09) else $error("add decode mask or opcode wrong");
  a_logic_zn_mask: assert property (DEC_VALID_OUT && DEC_OP_OUT inside {mwd_pkg::OP_WORKING_AND_FILE,
    mwd_pkg::OP_WORKING_OR_FILE, mwd_pkg::OP_WORKING_XOR_FILE, mwd_pkg::OP_FILE_COMPLEMENT}
    |-> FLAG_MASK_OUT == 5'h14 && word_q[15:12] == 4'h1) else $error("logic op mask wrong");
  a_mul_quiet: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_WORKING_TIMES_FILE
    |-> FLAG_MASK_OUT == 5'h00 && CYCLES_OUT == 2'h1 && word_q[15:9] == 7'h01) else $error("multiply decode wrong");
  a_rotate_carry: assert property (DEC_VALID_OUT && DEC_OP_OUT inside
    {mwd_pkg::OP_LEFT_ROTATE_THROUGH_CARRY, mwd_pkg::OP_RIGHT_ROTATE_THROUGH_CARRY}
    |-> FLAG_MASK_OUT == 5'h15 && word_q[15:12] == 4'h3) else $error("rotate through carry mask wrong");
  a_literal_byte: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_LITERAL
    |-> LITERAL_OUT == word_q[7:0]) else $error("literal not low byte");
  a_jump_target: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_ABSOLUTE_JUMP
    |-> TARGET_OUT[19:8] == word_q[11:0] && word_q[15:12] == 4'hF && CYCLES_OUT == 2'h2)
    else $error("jump target upper bits wrong");
  a_move_dest: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_FILE_TO_FILE_MOVE
    |-> DEST_ADDR_OUT == word_q[11:0] && word_q[15:12] == 4'hF) else $error("move destination wrong");
  a_bit_field: assert property (DEC_VALID_OUT && DEC_OP_OUT inside
    {mwd_pkg::OP_FILE_BIT_CLEAR, mwd_pkg::OP_BIT_TEST_SKIP_CLEAR}
    |-> BIT_SEL_OUT == word_q[11:9] && FLAG_MASK_OUT == 5'h00) else $error("bit position wrong");
  a_long_offset: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_UNCONDITIONAL_RELATIVE_JUMP
    |-> REL_OFFSET_OUT == word_q[10:0] && CYCLES_OUT == 2'h2) else $error("relative offset wrong");
  a_fill_after_jump: assert property (DEC_VALID_OUT && DEC_OP_OUT == mwd_pkg::OP_ABSOLUTE_JUMP
    ##1 DEC_VALID_OUT |-> DEC_OP_OUT == mwd_pkg::OP_NOP && FLAG_MASK_OUT == 5'h00) else $error("no fill after jump");
  a_pulse_cause: assert property (DEC_VALID_OUT |-> valid_q) else $error("pulse without a taken word");
endmodule
`default_nettype wire

// ### verification/mwd_prog_mem.sv
// program memory model presenting instruction words
`timescale 1ns/1ps
`default_nettype none
module mwd_prog_mem (
  input  wire logic        clk_in,
  output logic      [15:0] word_out,
  output logic             valid_out
);
  initial begin
    word_out  = 16'h0000;
    valid_out = 1'b0;
  end
  task automatic put(input logic [15:0] w);
    @(posedge clk_in);
    word_out  <= w;
    valid_out <= 1'b1;
  endtask
  // released bus shows the complement of its previous value
  task automatic idle();
    @(posedge clk_in);
    word_out  <= ~word_out;
    valid_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_mwd_decoder.sv
// self-checking bench for the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module tb_mwd_decoder;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cond_true = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, valid, dec_valid, dest_file, fast, skip_test, read_pins;
  logic [15:0] word;
  logic [5:0]  dec_op;
  logic [11:0] file_addr, dest_addr;
  logic [2:0]  bit_sel;
  logic [7:0]  literal;
  logic [19:0] target;
  logic [10:0] rel;
  logic [4:0]  mask;
  logic [1:0]  cycles;
  int          n_fail = 0, tests_run = 0, tick = 0;
  localparam logic [15:0] WDS [23] = '{16'h2644, 16'h2000, 16'h1400, 16'h1000, 16'h1800, 16'h1C00, 16'h0200,
    16'h6200, 16'h6400, 16'h6000, 16'h3C00, 16'h2C00, 16'h4800, 16'h4C00, 16'h3400, 16'h3000, 16'h4400,
    16'h4000, 16'h5C00, 16'h5800, 16'h5400, 16'h9000, 16'hB000};
  localparam logic [4:0] MSK [23] = '{5'h1F, 5'h1F, 5'h14, 5'h14, 5'h14, 5'h14, 5'h00, 5'h00, 5'h00, 5'h00,
    5'h00, 5'h00, 5'h00, 5'h00, 5'h15, 5'h15, 5'h14, 5'h14, 5'h1F, 5'h1F, 5'h1F, 5'h00, 5'h00};
  mwd_pkg::mwd_op_t ops [23] = '{mwd_pkg::OP_ADD_WORKING_TO_FILE, mwd_pkg::OP_ADD_WITH_CARRY_TO_FILE,
    mwd_pkg::OP_WORKING_AND_FILE, mwd_pkg::OP_WORKING_OR_FILE, mwd_pkg::OP_WORKING_XOR_FILE,
    mwd_pkg::OP_FILE_COMPLEMENT, mwd_pkg::OP_WORKING_TIMES_FILE, mwd_pkg::OP_COMPARE_SKIP_EQUAL,
    mwd_pkg::OP_COMPARE_SKIP_GREATER, mwd_pkg::OP_COMPARE_SKIP_LESS, mwd_pkg::OP_INCREMENT_SKIP_ZERO,
    mwd_pkg::OP_DECREMENT_SKIP_ZERO, mwd_pkg::OP_INCREMENT_SKIP_NONZERO, mwd_pkg::OP_DECREMENT_SKIP_NONZERO,
    mwd_pkg::OP_LEFT_ROTATE_THROUGH_CARRY, mwd_pkg::OP_RIGHT_ROTATE_THROUGH_CARRY, mwd_pkg::OP_LEFT_ROTATE_PLAIN,
    mwd_pkg::OP_RIGHT_ROTATE_PLAIN, mwd_pkg::OP_FILE_MINUS_WORKING, mwd_pkg::OP_FILE_MINUS_WORKING_BORROW,
    mwd_pkg::OP_WORKING_MINUS_FILE_BORROW, mwd_pkg::OP_FILE_BIT_CLEAR, mwd_pkg::OP_BIT_TEST_SKIP_CLEAR};
  mwd_prog_mem i_mwd_prog_mem (.clk_in(clk), .word_out(word), .valid_out(valid));
  mwd_decoder i_mwd_decoder (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .INSTR_WORD_IN(word), .INSTR_VALID_IN(valid), .COND_TRUE_IN(cond_true), .DEC_VALID_OUT(dec_valid),
    .DEC_OP_OUT(dec_op), .DEST_FILE_OUT(dest_file), .FILE_ADDR_OUT(file_addr), .DEST_ADDR_OUT(dest_addr),
    .BIT_SEL_OUT(bit_sel), .LITERAL_OUT(literal), .TARGET_OUT(target), .REL_OFFSET_OUT(rel), .FAST_OUT(fast),
    .FLAG_MASK_OUT(mask), .CYCLES_OUT(cycles), .SKIP_TEST_OUT(skip_test), .READ_PINS_OUT(read_pins)
  );
  always #10 clk = ~clk;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    tick++;
    if (tick == 2000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_dec(input mwd_pkg::mwd_op_t op, input logic [4:0] m);
    chk(32'(dec_valid), 32'h1);
    chk(32'(dec_op), 32'(op));
    chk(32'(mask), 32'(m));
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    if (!wr) chk(prdata, exp);
    chk(32'(pslverr), 32'(err));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(input logic [15:0] w);
    i_mwd_prog_mem.put(w);
  endtask
  task automatic fin();
    i_mwd_prog_mem.idle();
    #1;
  endtask
  task automatic fire(input logic [15:0] w);
    put(w);
    fin();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h0C, 32'h1, 32'h0, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 23; i++) begin
      fire(WDS[i]);
      chk_dec(ops[i], MSK[i]);
    end
    apb(1'b1, 8'h08, 32'h5, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'd23, 1'b0);
    apb(1'b1, 8'h00, 32'h5, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 32'h0, 32'h5, 1'b0);
    fire(16'h2744);
    chk(32'(file_addr), 32'h544);
    chk(32'(dest_file), 32'h1);
    fire(16'h2444);
    chk(32'(file_addr), 32'h044);
    chk(32'(dest_file), 32'h0);
    apb(1'b1, 8'h00, 32'hF, 32'h0, 1'b0);
    fire(16'h2780);
    chk(32'(read_pins), 32'h1);
    fire(16'h2680);
    chk(32'(read_pins), 32'h0);
    fire(16'h9B44);
    chk(32'(bit_sel), 32'h5);
    chk(32'(file_addr), 32'hF44);
    fire(16'h0F7F);
    chk(32'(literal), 32'h7F);
    put(16'hC123);
    put(16'hF456);
    #1 chk(32'(dec_valid), 32'h0);
    fin();
    chk_dec(mwd_pkg::OP_FILE_TO_FILE_MOVE, 5'h00);
    chk({8'h0, file_addr, dest_addr}, 32'h0012_3456);
    chk(32'(cycles), 32'h2);
    put(16'hEF12);
    put(16'hF345);
    put(16'h2644);
    #1 chk_dec(mwd_pkg::OP_ABSOLUTE_JUMP, 5'h00);
    chk(32'(target), 32'h3_4512);
    chk(32'(fast), 32'h0);
    fin();
    chk_dec(mwd_pkg::OP_NOP, 5'h00);
    put(16'hED12);
    put(16'hFABC);
    put(16'h0000);
    #1 chk(32'(target), 32'hA_BC12);
    chk(32'(fast), 32'h1);
    fin();
    put(16'hD7FF);
    put(16'h2644);
    #1 chk(32'(rel), 32'h7FF);
    fin();
    chk_dec(mwd_pkg::OP_NOP, 5'h00);
    fire(16'hE280);
    chk(32'(rel), 32'h780);
    put(16'h6244);
    put(16'hC123);
    cond_true <= 1'b1;
    #1 chk(32'(skip_test), 32'h1);
    put(16'hF456);
    cond_true <= 1'b0;
    #1 chk_dec(mwd_pkg::OP_NOP, 5'h00);
    fin();
    chk_dec(mwd_pkg::OP_NOP, 5'h00);
    put(16'hC123);
    fire(16'h2644);
    chk_dec(mwd_pkg::OP_UNDECODED, 5'h00);
    apb(1'b0, 8'h04, 32'h0, 32'h1000 | 32'(mwd_pkg::OP_UNDECODED), 1'b0);
    close_out();
  end
endmodule
bind mwd_decoder mwd_decoder_checker i_mwd_decoder_checker (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .INSTR_WORD_IN(INSTR_WORD_IN), .INSTR_VALID_IN(INSTR_VALID_IN), .DEC_VALID_OUT(DEC_VALID_OUT),
  .DEC_OP_OUT(DEC_OP_OUT), .FLAG_MASK_OUT(FLAG_MASK_OUT), .LITERAL_OUT(LITERAL_OUT), .TARGET_OUT(TARGET_OUT),
  .DEST_ADDR_OUT(DEST_ADDR_OUT), .BIT_SEL_OUT(BIT_SEL_OUT), .REL_OFFSET_OUT(REL_OFFSET_OUT),
  .CYCLES_OUT(CYCLES_OUT));
`default_nettype wire
